// ### inc/ccr_pkg.sv
// Purpose: constants and types of the counter configuration register bank
// Assumes: 16-bit holding registers addressed by word index
// Notes:   paired registers hold 32-bit two's complement, high word first
package ccr_pkg;
   // ****************************************
   // Register indexes
   // ****************************************
   localparam logic [7:0] ADDR_MUL_HI    = 8'h16;
   localparam logic [7:0] ADDR_MUL_LO    = 8'h17;
   localparam logic [7:0] ADDR_DIV_HI    = 8'h18;
   localparam logic [7:0] ADDR_DIV_LO    = 8'h19;
   localparam logic [7:0] ADDR_OFS_HI    = 8'h1a;
   localparam logic [7:0] ADDR_OFS_LO    = 8'h1b;
   localparam logic [7:0] ADDR_POINT     = 8'h1c;
   localparam logic [7:0] ADDR_STATION   = 8'h20;
   localparam logic [7:0] ADDR_IDENT     = 8'h21;
   localparam logic [7:0] ADDR_RATE      = 8'h22;
   localparam logic [7:0] ADDR_PERMIT    = 8'h23;
   localparam logic [7:0] ADDR_LOCKS     = 8'h24;
   localparam logic [7:0] ADDR_DELAY     = 8'h25;
   localparam logic [7:0] ADDR_SILENCE   = 8'h27;
   localparam logic [7:0] ADDR_LEVEL     = 8'h2d;
   localparam logic [7:0] ADDR_EDIT      = 8'h2f;
   localparam logic [7:0] ADDR_THR_HI    = 8'h30;
   localparam logic [7:0] ADDR_THR_LO    = 8'h31;
   localparam logic [7:0] ADDR_RELAY     = 8'h32;

   // ****************************************
   // Field limits
   // ****************************************
   localparam logic signed [31:0] MUL_MIN  = -32'sd99999;
   localparam logic signed [31:0] MUL_MAX  = 32'sd999999;
   localparam logic signed [31:0] DIV_MIN  = 32'sd1;
   localparam logic signed [31:0] DIV_MAX  = 32'sd999999;
   localparam logic signed [31:0] OFS_MIN  = -32'sd999999;
   localparam logic signed [31:0] OFS_MAX  = 32'sd999999;
   localparam logic signed [31:0] THR_MIN  = -32'sd99999;
   localparam logic signed [31:0] THR_MAX  = 32'sd999999;
   localparam logic [15:0] POINT_MAX      = 16'h0005;
   localparam logic [15:0] STATION_MAX    = 16'h00c7;
   localparam logic [15:0] RATE_MAX       = 16'h0007;
   localparam logic [15:0] PERMIT_MAX     = 16'h0001;
   localparam logic [15:0] LOCKS_MASK     = 16'h001f;
   localparam logic [15:0] DELAY_MAX      = 16'h0005;
   localparam logic [15:0] SILENCE_MAX    = 16'h0063;
   localparam logic [15:0] LEVEL_MIN      = 16'h0001;
   localparam logic [15:0] LEVEL_MAX      = 16'h0008;
   localparam logic [15:0] EDIT_MAX       = 16'h0001;
   localparam logic [15:0] RELAY_MAX      = 16'h0003;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [31:0] RST_MUL     = 32'h0000_0001;
   localparam logic [31:0] RST_DIV     = 32'h0000_0001;
   localparam logic [31:0] RST_OFS     = 32'h0000_0000;
   localparam logic [31:0] RST_THR     = 32'h0000_0000;
   localparam logic [15:0] RST_POINT   = 16'h0000;
   localparam logic [15:0] RST_STATION = 16'h0001;
   localparam logic [15:0] RST_RATE    = 16'h0003;
   localparam logic [15:0] RST_PERMIT  = 16'h0001;
   localparam logic [15:0] RST_LOCKS   = 16'h0000;
   localparam logic [15:0] RST_DELAY   = 16'h0000;
   localparam logic [15:0] RST_SILENCE = 16'h0000;
   localparam logic [15:0] RST_LEVEL   = 16'h0008;
   localparam logic [15:0] RST_EDIT    = 16'h0000;
   localparam logic [15:0] RST_RELAY   = 16'h0000;
   // Arbitrary identity value
   localparam logic [15:0] IDENT_VALUE = 16'h5a3c;

   // ****************************************
   // Answer codes
   // ****************************************
   localparam logic [7:0] EXC_NONE      = 8'h00;
   localparam logic [7:0] EXC_ADDRESS   = 8'h02;
   localparam logic [7:0] EXC_VALUE     = 8'h03;
   localparam logic [7:0] EXC_NO_PERMIT = 8'h08;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [1:0] {
      RELAY_IDLE_ACTION,
      RELAY_ON,
      RELAY_OFF,
      RELAY_REMOTE
   } ccr_relay_mode_t;

   typedef enum logic [2:0] {
      BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600,
      BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
   } ccr_baud_t;

   // Reply delay in character periods per code
   localparam logic [7:0] DELAY_CHARS_1 = 8'd10;
   localparam logic [7:0] DELAY_CHARS_2 = 8'd20;
   localparam logic [7:0] DELAY_CHARS_3 = 8'd50;
   localparam logic [7:0] DELAY_CHARS_4 = 8'd100;
   localparam logic [7:0] DELAY_CHARS_5 = 8'd200;
endpackage

// ### src/ccr_prescaler.sv
// Purpose: precounter and prescaled display value
// Assumes: event pulses already decoded per counting mode
// Notes:   display = count * multiplier + offset
`timescale 1ns/100ps
`default_nettype none
module ccr_prescaler (
   input  wire logic               i_mclk,
   input  wire logic               i_rst,
   input  wire logic               i_event,
   input  wire logic               i_down,
   input  wire logic [31:0]        i_divider,
   input  wire logic signed [31:0] i_multiplier,
   input  wire logic signed [31:0] i_offset,
   output logic signed [31:0]      o_count,
   output logic signed [31:0]      o_display
);
   typedef struct packed {
      logic [31:0]        pre;
      logic signed [31:0] count;
      logic signed [31:0] disp;
   } ccr_pre_state_t;

   ccr_pre_state_t st;
   ccr_pre_state_t next_st;
   logic signed [63:0] prod;

   always_comb begin
      next_st = st;
      prod    = 64'(st.count) * 64'(i_multiplier);
      if (i_event) begin
         if (st.pre + 32'd1 >= i_divider) begin
            next_st.pre = 32'd0;
            if (i_down) begin
               next_st.count = st.count - 32'sd1;
            end else begin
               next_st.count = st.count + 32'sd1;
            end
         end else begin
            next_st.pre = st.pre + 32'd1;
         end
      end
      next_st.disp = 32'(prod) + i_offset;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_count   = st.count;
   assign o_display = st.disp;
endmodule
`default_nettype wire

// ### src/ccr_range_check.sv
// Purpose: signed window check on a 32-bit paired value
// Assumes: limits are two's complement
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module ccr_range_check (
   input  wire logic signed [31:0] i_value,
   input  wire logic signed [31:0] i_min,
   input  wire logic signed [31:0] i_max,
   output logic                    o_ok
);
   assign o_ok = (i_value >= i_min) && (i_value <= i_max);
endmodule
`default_nettype wire

// ### src/ccr_register_bank.sv
// Purpose: holding-register bank of a pulse and quadrature counter
// Assumes: serial framing decoded outside; one write or read strobe per request
// Notes:   answers one cycle after a strobe with data and exception code
//
// Function
// - Paired multiplier accepted only within -99999 to 999999.
// - Display is always prescaled counter, never raw count.
// - Main counter moves once every divider-count input events.
// - Paired divider accepted only within 1 to 999999.
// - Paired offset accepted only within -999999 to 999999.
// - Decimal point codes 0 to 5, digits after point.
// - Identity register is read only and fixed.
// - Line rate codes 0 to 7 select 1200 to 115200 baud.
// - Writes refused while permission is 0, accepted at 1.
// - Lock register has five bits: four relays and offset.
// - Reply delay codes 0 to 5: none to 200 characters.
// - Silence limit 0 disables, 1 to 99 seconds.
// - Brightness 1 dimmest to 8 brightest.
// - Edit style 0 per digit, 1 sliding.
// - Relay one threshold accepted within -99999 to 999999.
// - Relay one mode codes 0 to 3.
// - Permission may be cleared remotely, never set remotely.
// - Bad value answers 03h, forbidden write answers 08h.
`timescale 1ns/100ps
`default_nettype none
module ccr_register_bank (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_local_permit,
   input  wire logic        i_event,
   input  wire logic        i_down,
   output logic             o_ack,
   output logic [15:0]      o_rdata,
   output logic [7:0]       o_exception,
   output logic [2:0]       o_baud_code,
   output logic [7:0]       o_reply_chars,
   output logic [6:0]       o_silence_s,
   output logic [7:0]       o_station,
   output logic [2:0]       o_point,
   output logic [3:0]       o_level,
   output logic             o_sliding_entry,
   output logic [3:0]       o_relay_lock,
   output logic             o_offset_lock,
   output logic [1:0]       o_relay1_mode,
   output logic [31:0]      o_relay1_threshold,
   output logic [31:0]      o_display
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [31:0] mul;
      logic [31:0] div;
      logic [31:0] ofs;
      logic [31:0] thr;
      logic [15:0] point;
      logic [15:0] station;
      logic [15:0] rate;
      logic [15:0] permit;
      logic [15:0] locks;
      logic [15:0] delay;
      logic [15:0] silence;
      logic [15:0] level;
      logic [15:0] edit;
      logic [15:0] relay;
      logic        ack;
      logic [15:0] rdata;
      logic [7:0]  exc;
      logic [7:0]  chars;
      logic [31:0] disp;
      logic [2:0]  lp_sync;
      logic        lp_req;
   } ccr_state_t;

   ccr_state_t st;
   ccr_state_t next_st;

   logic signed [31:0] cand;
   logic signed [31:0] lo_min;
   logic signed [31:0] lo_max;
   logic               in_range;
   logic signed [31:0] disp;
   logic               thr_fix_ok;

   function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
                                            input logic [15:0] w);
      put_half = hi ? {w, old[15:0]} : {old[31:16], w};
   endfunction

   function automatic logic [7:0] delay_chars(input logic [15:0] code);
      case (code[2:0])
         3'h1:    delay_chars = ccr_pkg::DELAY_CHARS_1;
         3'h2:    delay_chars = ccr_pkg::DELAY_CHARS_2;
         3'h3:    delay_chars = ccr_pkg::DELAY_CHARS_3;
         3'h4:    delay_chars = ccr_pkg::DELAY_CHARS_4;
         3'h5:    delay_chars = ccr_pkg::DELAY_CHARS_5;
         default: delay_chars = 8'h00;
      endcase
   endfunction

   // Candidate pair value and its window
   always_comb begin
      cand   = 32'sd0;
      lo_min = 32'sd0;
      lo_max = 32'sd0;
      case (i_addr)
         ccr_pkg::ADDR_MUL_HI, ccr_pkg::ADDR_MUL_LO: begin
            cand   = put_half(st.mul, i_addr == ccr_pkg::ADDR_MUL_HI, i_wdata);
            lo_min = ccr_pkg::MUL_MIN;
            lo_max = ccr_pkg::MUL_MAX;
         end
         ccr_pkg::ADDR_DIV_HI, ccr_pkg::ADDR_DIV_LO: begin
            cand   = put_half(st.div, i_addr == ccr_pkg::ADDR_DIV_HI, i_wdata);
            lo_min = ccr_pkg::DIV_MIN;
            lo_max = ccr_pkg::DIV_MAX;
         end
         ccr_pkg::ADDR_OFS_HI, ccr_pkg::ADDR_OFS_LO: begin
            cand   = put_half(st.ofs, i_addr == ccr_pkg::ADDR_OFS_HI, i_wdata);
            lo_min = ccr_pkg::OFS_MIN;
            lo_max = ccr_pkg::OFS_MAX;
         end
         ccr_pkg::ADDR_THR_HI, ccr_pkg::ADDR_THR_LO: begin
            cand   = put_half(st.thr, i_addr == ccr_pkg::ADDR_THR_HI, i_wdata);
            lo_min = ccr_pkg::THR_MIN;
            lo_max = ccr_pkg::THR_MAX;
         end
         default: cand = 32'sd0;
      endcase
   end

   ccr_range_check u_range (
      .i_value (cand),
      .i_min   (lo_min),
      .i_max   (lo_max),
      .o_ok    (in_range)
   );

   // ****************************************
   // Prescaled counter
   // ****************************************
   ccr_prescaler u_pre (
      .i_mclk       (i_mclk),
      .i_rst        (i_rst),
      .i_event      (i_event),
      .i_down       (i_down),
      .i_divider    (st.div),
      .i_multiplier (st.mul),
      .i_offset     (st.ofs),
      .o_count      (),
      .o_display    (disp)
   );

   // Threshold high-word write: low word corrected when possible
   assign thr_fix_ok = ($signed({i_wdata, 16'h0000}) <= ccr_pkg::THR_MAX) &&
                       ($signed({i_wdata, 16'hffff}) >= ccr_pkg::THR_MIN);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st       = st;
      next_st.ack   = 1'b0;
      next_st.disp  = disp;
      next_st.chars = delay_chars(st.delay);
      // Local menu enable crosses from a pin: three stages
      next_st.lp_sync = {st.lp_sync[1:0], i_local_permit};
      next_st.lp_req  = st.lp_sync[2] & st.lp_sync[1];
      if (i_rd) begin
         next_st.ack   = 1'b1;
         next_st.exc   = ccr_pkg::EXC_NONE;
         next_st.rdata = 16'h0000;
         case (i_addr)
            ccr_pkg::ADDR_MUL_HI:  next_st.rdata = st.mul[31:16];
            ccr_pkg::ADDR_MUL_LO:  next_st.rdata = st.mul[15:0];
            ccr_pkg::ADDR_DIV_HI:  next_st.rdata = st.div[31:16];
            ccr_pkg::ADDR_DIV_LO:  next_st.rdata = st.div[15:0];
            ccr_pkg::ADDR_OFS_HI:  next_st.rdata = st.ofs[31:16];
            ccr_pkg::ADDR_OFS_LO:  next_st.rdata = st.ofs[15:0];
            ccr_pkg::ADDR_POINT:   next_st.rdata = st.point;
            ccr_pkg::ADDR_STATION: next_st.rdata = st.station;
            ccr_pkg::ADDR_IDENT:   next_st.rdata = ccr_pkg::IDENT_VALUE;
            ccr_pkg::ADDR_RATE:    next_st.rdata = st.rate;
            ccr_pkg::ADDR_PERMIT:  next_st.rdata = st.permit;
            ccr_pkg::ADDR_LOCKS:   next_st.rdata = st.locks;
            ccr_pkg::ADDR_DELAY:   next_st.rdata = st.delay;
            ccr_pkg::ADDR_SILENCE: next_st.rdata = st.silence;
            ccr_pkg::ADDR_LEVEL:   next_st.rdata = st.level;
            ccr_pkg::ADDR_EDIT:    next_st.rdata = st.edit;
            ccr_pkg::ADDR_THR_HI:  next_st.rdata = st.thr[31:16];
            ccr_pkg::ADDR_THR_LO:  next_st.rdata = st.thr[15:0];
            ccr_pkg::ADDR_RELAY:   next_st.rdata = st.relay;
            default:               next_st.exc   = ccr_pkg::EXC_ADDRESS;
         endcase
      end else if (i_wr) begin
         next_st.ack   = 1'b1;
         next_st.rdata = i_wdata;
         next_st.exc   = ccr_pkg::EXC_NONE;
         if (st.permit[0] == 1'b0) begin
            next_st.exc = ccr_pkg::EXC_NO_PERMIT;
         end else begin
            case (i_addr)
               ccr_pkg::ADDR_MUL_HI, ccr_pkg::ADDR_MUL_LO: begin
                  if (in_range) next_st.mul = cand;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_DIV_HI, ccr_pkg::ADDR_DIV_LO: begin
                  if (in_range) next_st.div = cand;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_OFS_HI, ccr_pkg::ADDR_OFS_LO: begin
                  if (in_range) next_st.ofs = cand;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               // Threshold window, high word corrects low
               ccr_pkg::ADDR_THR_HI: begin
                  if (in_range) begin
                     next_st.thr = cand;
                  end else if (thr_fix_ok) begin
                     next_st.thr = ($signed(cand) > ccr_pkg::THR_MAX) ?
                                   ccr_pkg::THR_MAX : ccr_pkg::THR_MIN;
                  end else begin
                     next_st.exc = ccr_pkg::EXC_VALUE;
                  end
               end
               ccr_pkg::ADDR_THR_LO: begin
                  if (in_range) next_st.thr = cand;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_POINT: begin
                  if (i_wdata <= ccr_pkg::POINT_MAX) next_st.point = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_STATION: begin
                  if (i_wdata <= ccr_pkg::STATION_MAX) next_st.station = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_IDENT: begin
                  next_st.exc = ccr_pkg::EXC_ADDRESS;
               end
               ccr_pkg::ADDR_RATE: begin
                  if (i_wdata <= ccr_pkg::RATE_MAX) next_st.rate = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_PERMIT: begin
                  if (i_wdata == 16'h0000) next_st.permit = 16'h0000;
                  else if (i_wdata <= ccr_pkg::PERMIT_MAX) next_st.permit = st.permit;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_LOCKS: begin
                  if ((i_wdata & ~ccr_pkg::LOCKS_MASK) == 16'h0000) next_st.locks = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_DELAY: begin
                  if (i_wdata <= ccr_pkg::DELAY_MAX) next_st.delay = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_SILENCE: begin
                  if (i_wdata <= ccr_pkg::SILENCE_MAX) next_st.silence = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_LEVEL: begin
                  if (i_wdata >= ccr_pkg::LEVEL_MIN && i_wdata <= ccr_pkg::LEVEL_MAX) begin
                     next_st.level = i_wdata;
                  end else begin
                     next_st.exc = ccr_pkg::EXC_VALUE;
                  end
               end
               ccr_pkg::ADDR_EDIT: begin
                  if (i_wdata <= ccr_pkg::EDIT_MAX) next_st.edit = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               ccr_pkg::ADDR_RELAY: begin
                  if (i_wdata <= ccr_pkg::RELAY_MAX) next_st.relay = i_wdata;
                  else next_st.exc = ccr_pkg::EXC_VALUE;
               end
               default: next_st.exc = ccr_pkg::EXC_ADDRESS;
            endcase
         end
      end
      // Local menu re-enables writes; set beats a remote clear
      if (st.lp_req) begin
         next_st.permit = 16'h0001;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st         <= '0;
         st.mul     <= ccr_pkg::RST_MUL;
         st.div     <= ccr_pkg::RST_DIV;
         st.ofs     <= ccr_pkg::RST_OFS;
         st.thr     <= ccr_pkg::RST_THR;
         st.point   <= ccr_pkg::RST_POINT;
         st.station <= ccr_pkg::RST_STATION;
         st.rate    <= ccr_pkg::RST_RATE;
         st.permit  <= ccr_pkg::RST_PERMIT;
         st.locks   <= ccr_pkg::RST_LOCKS;
         st.delay   <= ccr_pkg::RST_DELAY;
         st.silence <= ccr_pkg::RST_SILENCE;
         st.level   <= ccr_pkg::RST_LEVEL;
         st.edit    <= ccr_pkg::RST_EDIT;
         st.relay   <= ccr_pkg::RST_RELAY;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_ack              = st.ack;
   assign o_rdata            = st.rdata;
   assign o_exception        = st.exc;
   assign o_baud_code        = st.rate[2:0];
   assign o_reply_chars      = st.chars;
   assign o_silence_s        = st.silence[6:0];
   assign o_station          = st.station[7:0];
   assign o_point            = st.point[2:0];
   assign o_level            = st.level[3:0];
   assign o_sliding_entry    = st.edit[0];
   assign o_relay_lock       = st.locks[3:0];
   assign o_offset_lock      = st.locks[4];
   assign o_relay1_mode      = st.relay[1:0];
   assign o_relay1_threshold = st.thr;
   assign o_display          = st.disp;
endmodule
`default_nettype wire

// ### testbench/ccr_checker.sv
// Purpose: port checker for the register bank
// Assumes: one clock, reset active high
// Notes:   answers and field windows
`timescale 1ns/100ps
`default_nettype none
module ccr_checker (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        o_ack,
   input wire logic [7:0]  o_exception,
   input wire logic [2:0]  o_point,
   input wire logic [3:0]  o_level,
   input wire logic [7:0]  o_reply_chars,
   input wire logic [6:0]  o_silence_s,
   input wire logic [31:0] o_relay1_threshold
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   sequence s_req; i_wr || i_rd; endsequence
   sequence s_wr(a); i_wr && !i_rd && i_addr == a; endsequence
   property p_answer; s_req |=> o_ack; endproperty
   property p_quiet; !(i_wr || i_rd) |=> !o_ack; endproperty
   property p_ident; s_wr(ccr_pkg::ADDR_IDENT) |=> o_exception == 8'h02; endproperty
   property p_rate; s_wr(ccr_pkg::ADDR_RATE) ##0 i_wdata > 16'h0007 |=> o_exception == 8'h03;
   endproperty
   property p_point; o_point <= 3'h5; endproperty
   property p_level; o_level >= 4'h1 && o_level <= 4'h8; endproperty
   property p_delay; o_reply_chars inside {8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
   endproperty
   property p_silence; o_silence_s <= 7'h63; endproperty
   property p_thr; $signed(o_relay1_threshold) >= ccr_pkg::THR_MIN &&
      $signed(o_relay1_threshold) <= ccr_pkg::THR_MAX; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   a_quiet: assert property (p_quiet) else $error("stray answer");
   a_ident: assert property (p_ident) else $error("identity written");
   a_rate: assert property (p_rate) else $error("rate taken");
   a_point: assert property (p_point) else $error("point range");
   a_level: assert property (p_level) else $error("level range");
   a_delay: assert property (p_delay) else $error("delay table");
   a_silence: assert property (p_silence) else $error("silence range");
   a_thr: assert property (p_thr) else $error("threshold range");
endmodule
`default_nettype wire

// ### testbench/ccr_master.sv
// Purpose: bus master model for the register port
// Assumes: answer one edge after the strobe
// Notes:   released address and data lines show inverted last value, strobes drop to 0
`timescale 1ns/100ps
`default_nettype none
module ccr_master (
   input  wire logic   i_mclk,
   input  wire logic   i_ack,
   output logic        o_wr = 1'b0,
   output logic        o_rd = 1'b0,
   output logic [7:0]  o_addr = 8'h00,
   output logic [15:0] o_wdata = 16'h0000
);
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic ok);
      ok = 1'b0;
      @(posedge i_mclk);
      o_wr <= w;
      o_rd <= ~w;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_mclk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
      for (int k = 0; k < 4 && !ok; k++) begin
         @(negedge i_mclk);
         ok = (i_ack === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/counter_config_register_bank_test.sv
// Purpose: scenario bench for the register bank
// Assumes: permit cleared only in the last scenario
// Notes:   every wait is bounded
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module counter_config_register_bank_test;
   logic i_mclk, i_rst, i_local_permit, i_event, i_down, ok, wr, rd, ack, slide, olock;
   logic [7:0] addr, exc, chars, station;
   logic [15:0] wdata, rdata;
   logic [2:0] baud;
   logic [1:0] rmode;
   logic [3:0] level, rlock;
   logic [31:0] thr, disp;
   int n_fail = 0;
   int checked = 0;
   ccr_master m (.i_mclk(i_mclk), .i_ack(ack), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata));
   ccr_register_bank dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(wr), .i_rd(rd),
      .i_addr(addr), .i_wdata(wdata), .i_local_permit(i_local_permit), .i_event(i_event),
      .i_down(i_down), .o_ack(ack), .o_rdata(rdata), .o_exception(exc), .o_baud_code(baud),
      .o_reply_chars(chars), .o_silence_s(), .o_station(station), .o_point(), .o_level(level),
      .o_sliding_entry(slide), .o_relay_lock(rlock), .o_offset_lock(olock),
      .o_relay1_mode(rmode), .o_relay1_threshold(thr), .o_display(disp));
   task automatic finish_test();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [7:0] e);
      m.xfer(w, a, d, ok);
      if (ok !== 1'b1) begin
         n_fail++;
         finish_test();
      end else `CHK(exc, e)
   endtask
   task automatic t_ident();
      acc(0, ccr_pkg::ADDR_IDENT, 16'h0000, 8'h00);
      `CHK(rdata, ccr_pkg::IDENT_VALUE)
      acc(1, ccr_pkg::ADDR_IDENT, 16'h1234, 8'h02);
      acc(0, ccr_pkg::ADDR_IDENT, 16'h0000, 8'h00);
      `CHK(rdata, ccr_pkg::IDENT_VALUE)
      acc(0, 8'h1d, 16'h0000, 8'h02);
      $display("ident done");
   endtask
   task automatic t_pairs();
      acc(1, ccr_pkg::ADDR_MUL_HI, 16'hffff, 8'h00);
      acc(1, ccr_pkg::ADDR_MUL_HI, 16'hfffe, 8'h03);
      acc(1, ccr_pkg::ADDR_DIV_LO, 16'h0000, 8'h03);
      acc(1, ccr_pkg::ADDR_OFS_HI, 16'h000f, 8'h00);
      acc(1, ccr_pkg::ADDR_OFS_LO, 16'h423f, 8'h00);
      acc(1, ccr_pkg::ADDR_OFS_LO, 16'h4240, 8'h03);
      acc(0, ccr_pkg::ADDR_OFS_LO, 16'h0000, 8'h00);
      `CHK(rdata, 16'h423f)
      acc(1, ccr_pkg::ADDR_THR_LO, 16'hffff, 8'h00);
      acc(1, ccr_pkg::ADDR_THR_HI, 16'h000f, 8'h00);
      `CHK(thr, 32'h000f423f)
      acc(1, ccr_pkg::ADDR_THR_LO, 16'hffff, 8'h03);
      `CHK(thr, 32'h000f423f)
      acc(1, ccr_pkg::ADDR_THR_HI, 16'hfffe, 8'h00);
      `CHK(thr, 32'hfffe7961)
      $display("pairs done");
   endtask
   task automatic t_codes();
      logic [7:0] dly [6] = '{8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
      for (int c = 0; c < 9; c++) begin
         acc(1, ccr_pkg::ADDR_RATE, 16'(c), c < 8 ? 8'h00 : 8'h03);
         `CHK(baud, 3'(c < 8 ? c : 7))
      end
      for (int c = 0; c < 7; c++) begin
         acc(1, ccr_pkg::ADDR_DELAY, 16'(c), c < 6 ? 8'h00 : 8'h03);
         @(negedge i_mclk) `CHK(chars, dly[c < 6 ? c : 5])
      end
      acc(1, ccr_pkg::ADDR_POINT, 16'h0006, 8'h03);
      acc(1, ccr_pkg::ADDR_POINT, 16'h0005, 8'h00);
      acc(1, ccr_pkg::ADDR_LEVEL, 16'h0000, 8'h03);
      acc(1, ccr_pkg::ADDR_LEVEL, 16'h0001, 8'h00);
      `CHK(level, 4'h1)
      acc(1, ccr_pkg::ADDR_EDIT, 16'h0001, 8'h00);
      `CHK(slide, 1'b1)
      acc(1, ccr_pkg::ADDR_LOCKS, 16'h001f, 8'h00);
      `CHK({olock, rlock}, 5'h1f)
      acc(1, ccr_pkg::ADDR_LOCKS, 16'h0020, 8'h03);
      acc(1, ccr_pkg::ADDR_RELAY, 16'h0003, 8'h00);
      `CHK(rmode, 2'h3)
      acc(1, ccr_pkg::ADDR_RELAY, 16'h0004, 8'h03);
      acc(1, ccr_pkg::ADDR_STATION, 16'h00c8, 8'h03);
      `CHK(station, 8'(ccr_pkg::RST_STATION))
      acc(1, ccr_pkg::ADDR_SILENCE, 16'h0064, 8'h03);
      $display("codes done");
   endtask
   task automatic t_count();
      acc(1, ccr_pkg::ADDR_MUL_HI, 16'h0000, 8'h00);
      acc(1, ccr_pkg::ADDR_MUL_LO, 16'h0003, 8'h00);
      acc(1, ccr_pkg::ADDR_DIV_LO, 16'h0002, 8'h00);
      acc(1, ccr_pkg::ADDR_OFS_HI, 16'h0000, 8'h00);
      acc(1, ccr_pkg::ADDR_OFS_LO, 16'h0005, 8'h00);
      repeat (4) @(posedge i_mclk);
      `CHK(disp, 32'h00000005)
      repeat (4) begin
         @(posedge i_mclk) i_event <= 1'b1;
         @(posedge i_mclk) i_event <= 1'b0;
      end
      repeat (5) @(posedge i_mclk);
      `CHK(disp, 32'h0000000b)
      $display("count done");
   endtask
   task automatic t_permit();
      acc(1, ccr_pkg::ADDR_PERMIT, 16'h0000, 8'h00);
      acc(1, ccr_pkg::ADDR_LEVEL, 16'h0004, 8'h08);
      `CHK(level, 4'h1)
      acc(1, ccr_pkg::ADDR_PERMIT, 16'h0001, 8'h08);
      @(posedge i_mclk) i_local_permit <= 1'b1;
      repeat (10) @(posedge i_mclk);
      acc(1, ccr_pkg::ADDR_LEVEL, 16'h0004, 8'h00);
      `CHK(level, 4'h4)
      $display("permit done");
   endtask
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   initial begin
      {i_rst, i_local_permit, i_event, i_down} = 4'h8;
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      t_ident();
      t_pairs();
      t_codes();
      t_count();
      t_permit();
      finish_test();
   end
endmodule
bind ccr_register_bank ccr_checker chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(i_wr),
   .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack),
   .o_exception(o_exception), .o_point(o_point), .o_level(o_level),
   .o_reply_chars(o_reply_chars), .o_silence_s(o_silence_s),
   .o_relay1_threshold(o_relay1_threshold));
`default_nettype wire
